// ==== logic/mpm_cnt_timer.sv ====
`timescale 1ns/1ps
module mpm_cnt_timer #(
    parameter int W = 24
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         start,
    input  wire logic         stop,
    input  wire logic [W-1:0] load,
    output logic              busy,
    output logic              done
);

    logic [W-1:0] rem_q;

    generate
        if (W < 2) begin : g_chk
            $error("mpm_cnt_timer: W too small");
        end
    endgenerate

    // Start wins over stop so a restart in the same cycle is never lost
    always_ff @(posedge clk) begin
        if (rst) begin
            rem_q <= '0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else if (start) begin
            rem_q <= load;
            busy  <= 1'b1;
            done  <= 1'b0;
        end else if (stop) begin
            busy <= 1'b0;
            done <= 1'b0;
        end else if (busy && rem_q <= W'(1)) begin
            busy <= 1'b0;
            done <= 1'b1;
        end else begin
            rem_q <= busy ? rem_q - W'(1) : rem_q;
            done  <= 1'b0;
        end
    end

endmodule

// ==== logic/mpm_pkg.sv ====
package mpm_pkg;

    localparam int CLK_HZ   = 10_000_000;
    localparam int US_PER_S = 1_000_000;
    localparam int TW       = 24;

    localparam logic [7:0] ADDR_ID       = 8'h40;
    localparam logic [7:0] ADDR_XL       = 8'h42;
    localparam logic [7:0] ADDR_XM       = 8'h43;
    localparam logic [7:0] ADDR_YL       = 8'h44;
    localparam logic [7:0] ADDR_YM       = 8'h45;
    localparam logic [7:0] ADDR_ZL       = 8'h46;
    localparam logic [7:0] ADDR_ZM       = 8'h47;
    localparam logic [7:0] ADDR_RL       = 8'h48;
    localparam logic [7:0] ADDR_RM       = 8'h49;
    localparam logic [7:0] ADDR_PWR      = 8'h4b;
    localparam logic [7:0] ADDR_OPM      = 8'h4c;
    localparam logic [7:0] ADDR_AXEN     = 8'h4e;
    localparam logic [7:0] ADDR_XYREP    = 8'h51;
    localparam logic [7:0] ADDR_ZREP     = 8'h52;
    localparam logic [7:0] ADDR_NVM_BASE = 8'h5d;

    localparam int PWR_BIT       = 0;
    localparam int SRST_BIT      = 1;
    localparam int THREE_WIRE_SERIAL_ENABLE_BIT      = 2;
    localparam int OPM_MODE_LSB  = 1;
    localparam int OPM_RATE_LSB  = 3;
    localparam int AX_X          = 0;
    localparam int AX_Y          = 1;
    localparam int AX_Z          = 2;

    localparam logic [1:0] OPM_NORMAL = 2'h0;
    localparam logic [1:0] OPM_FORCED = 2'h1;
    localparam logic [1:0] OPM_SLEEP  = 2'h3;

    localparam logic [7:0] PWR_RST   = 8'h00;
    localparam logic [7:0] OPM_RST   = 8'h06;
    localparam logic [7:0] AXEN_RST  = 8'h07;
    localparam logic [7:0] REP_RST   = 8'h00;

    typedef enum logic [2:0] {
        MPM_ST_STARTUP,
        MPM_ST_SUSPEND,
        MPM_ST_SLEEP,
        MPM_ST_NORMAL,
        MPM_ST_FORCED
    } mpm_state_t;

    typedef int mpm_odr_tab_t [8];
    localparam mpm_odr_tab_t ODR_HZ = '{10, 2, 6, 8, 15, 20, 25, 30};

    function automatic mpm_odr_tab_t mpm_odr_table(int tick_hz);
        mpm_odr_tab_t t;
        for (int i = 0; i < 8; i++) begin
            t[i] = tick_hz / ODR_HZ[i];
        end
        return t;
    endfunction

endpackage

// ==== logic/mpm_top.sv ====
`timescale 1ns/1ps
module mpm_top
    import mpm_pkg::*;
#(
    parameter int         TICK_HZ     = CLK_HZ,
    parameter int         PLANAR_REPETITION_COUNT_US   = 145,
    parameter int         Z_REP_US    = 500,
    parameter int         MEAS_OVH_US = 980,
    parameter int         NVM_WORDS   = 8,
    parameter logic [7:0] ID_CODE     = 8'h5a
) (
    input  wire logic                         CLK_SYS,
    input  wire logic                         RST,
    input  wire logic                         VDD_OK,
    input  wire logic                         VDDIO_OK,
    input  wire logic                         IF_IS_SPI,
    input  wire logic                         REG_WR,
    input  wire logic                         REG_RD,
    input  wire logic [7:0]                   REG_ADDR,
    input  wire logic [7:0]                   REG_WDATA,
    output logic      [7:0]                   REG_RDATA,
    output logic                              REG_RD_ACK,
    output logic                              REG_SDO_OE,
    output logic                              NVM_RD,
    output logic      [$clog2(NVM_WORDS)-1:0] NVM_ADDR,
    input  wire logic [7:0]                   NVM_DATA,
    input  wire logic [12:0]                  AFE_X,
    input  wire logic [12:0]                  AFE_Y,
    input  wire logic [14:0]                  AFE_Z,
    input  wire logic [13:0]                  AFE_R,
    output logic      [2:0]                   AFE_AXIS_EN,
    output logic                              MEAS_ACTIVE,
    output logic                              DATA_UPDATED,
    output logic                              THREE_WIRE_EN,
    output logic      [2:0]                   MODE
);

    localparam int NAW = $clog2(NVM_WORDS);
    // Least times round up to whole cycles; longint avoids overflow of us * Hz
    localparam int PLANAR_REPETITION_COUNT_CYC =
        int'((longint'(PLANAR_REPETITION_COUNT_US) * TICK_HZ + US_PER_S - 1) / US_PER_S);
    localparam int Z_REP_CYC =
        int'((longint'(Z_REP_US) * TICK_HZ + US_PER_S - 1) / US_PER_S);
    localparam int MEAS_OVH_CYC =
        int'((longint'(MEAS_OVH_US) * TICK_HZ + US_PER_S - 1) / US_PER_S);
    localparam mpm_odr_tab_t ODR_CYC = mpm_odr_table(TICK_HZ);
    localparam int MAX_MEAS_CYC = (PLANAR_REPETITION_COUNT_CYC + Z_REP_CYC) * 256 + MEAS_OVH_CYC;

    generate
        if (NVM_WORDS < 2 || NVM_WORDS > 256 - int'(ADDR_NVM_BASE)) begin : g_chk_nvm
            $error("mpm_top: NVM_WORDS out of range");
        end
        if (MEAS_OVH_CYC < 1 || PLANAR_REPETITION_COUNT_CYC < 1 || Z_REP_CYC < 1) begin : g_chk_meas
            $error("mpm_top: measurement times shorter than one cycle");
        end
        if (MAX_MEAS_CYC >= (1 << TW) || ODR_CYC[1] >= (1 << TW) || ODR_CYC[7] < 1) begin : g_chk_tw
            $error("mpm_top: timer width too small for TICK_HZ");
        end
    endgenerate

    logic       vdd_s1_q, vdd_s2_q, vio_s1_q, vio_s2_q;
    logic       rst_int;
    mpm_state_t state_q, state_d;
    logic [7:0] pwr_q, opm_q, axen_q, xyrep_q, zrep_q;
    logic [7:0] nvm_shadow_q [NVM_WORDS];
    logic [NAW-1:0] nvm_idx_q;
    logic       nvm_last_q;
    logic       nvm_cap_q;
    logic [NAW-1:0] nvm_cap_addr_q;
    logic [12:0] dx_q, dy_q;
    logic [14:0] dz_q;
    logic [13:0] dr_q;
    logic       active, acc_ok_wr, acc_ok_rd, wr_pwr, wr_opm, srst;
    logic [1:0] opm_wmode;
    logic       forced_wr, norm_start, meas_start, meas_stop;
    logic       meas_busy, meas_done, odr_busy;
    logic [TW-1:0] meas_load, odr_load;
    logic [8:0] n_xy, n_z;
    logic [7:0] rd_mux;
    logic [7:0] nvm_off;

    // Supply-good levels cross from the analog domain
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            vdd_s1_q <= 1'b0;
            vdd_s2_q <= 1'b0;
            vio_s1_q <= 1'b0;
            vio_s2_q <= 1'b0;
        end else begin
            vdd_s1_q <= VDD_OK;
            vdd_s2_q <= vdd_s1_q;
            vio_s1_q <= VDDIO_OK;
            vio_s2_q <= vio_s1_q;
        end
    end

    assign rst_int = RST || !(vdd_s2_q && vio_s2_q);

    assign active = (state_q == MPM_ST_NORMAL) || (state_q == MPM_ST_FORCED);

    // Access gating by power mode
    always_comb begin
        acc_ok_wr = 1'b0;
        acc_ok_rd = 1'b0;
        case (state_q)
            MPM_ST_SUSPEND: begin
                acc_ok_wr = (REG_ADDR == ADDR_PWR);
                acc_ok_rd = (REG_ADDR == ADDR_PWR);
            end
            MPM_ST_SLEEP, MPM_ST_NORMAL, MPM_ST_FORCED: begin
                acc_ok_wr = 1'b1;
                acc_ok_rd = 1'b1;
            end
            default: begin
                acc_ok_wr = 1'b0;
                acc_ok_rd = 1'b0;
            end
        endcase
    end

    assign wr_pwr    = REG_WR && acc_ok_wr && (REG_ADDR == ADDR_PWR);
    assign wr_opm    = REG_WR && acc_ok_wr && (REG_ADDR == ADDR_OPM);
    assign opm_wmode = REG_WDATA[OPM_MODE_LSB +: 2];
    assign srst      = wr_pwr && REG_WDATA[SRST_BIT] && state_q != MPM_ST_SUSPEND;

    always_comb begin
        state_d = state_q;
        case (state_q)
            MPM_ST_STARTUP: begin
                if (nvm_last_q && NVM_RD) begin
                    state_d = MPM_ST_SUSPEND;
                end
            end
            MPM_ST_SUSPEND: begin
                if (wr_pwr && REG_WDATA[PWR_BIT]) begin
                    state_d = MPM_ST_SLEEP;
                end
            end
            MPM_ST_SLEEP, MPM_ST_NORMAL, MPM_ST_FORCED: begin
                if (wr_pwr && !REG_WDATA[PWR_BIT]) begin
                    state_d = MPM_ST_SUSPEND;
                end else if (srst) begin
                    state_d = MPM_ST_SLEEP;
                end else if (wr_opm) begin
                    if (opm_wmode == OPM_NORMAL) begin
                        state_d = MPM_ST_NORMAL;
                    end else if (opm_wmode == OPM_FORCED) begin
                        state_d = MPM_ST_FORCED;
                    end else begin
                        state_d = MPM_ST_SLEEP;
                    end
                end else if (state_q == MPM_ST_FORCED && meas_done) begin
                    state_d = MPM_ST_SLEEP;
                end
            end
            default: state_d = MPM_ST_STARTUP;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (rst_int) begin
            state_q <= MPM_ST_STARTUP;
        end else begin
            state_q <= state_d;
        end
    end

    // Start-up copy: one read strobe, data valid on the next cycle
    always_ff @(posedge CLK_SYS) begin
        if (rst_int) begin
            NVM_RD     <= 1'b0;
            NVM_ADDR   <= '0;
            nvm_idx_q  <= '0;
            nvm_last_q <= 1'b0;
        end else if (state_q == MPM_ST_STARTUP) begin
            if (!NVM_RD) begin
                NVM_RD     <= 1'b1;
                NVM_ADDR   <= nvm_idx_q;
                nvm_last_q <= (nvm_idx_q == NAW'(NVM_WORDS - 1));
            end else begin
                NVM_RD    <= 1'b0;
                nvm_idx_q <= nvm_idx_q + NAW'(1);
            end
        end else begin
            NVM_RD <= 1'b0;
        end
    end

    // Store data is valid one cycle after the strobe, so the capture trails it;
    // the last word lands in the first suspend cycle
    always_ff @(posedge CLK_SYS) begin
        if (rst_int) begin
            nvm_cap_q      <= 1'b0;
            nvm_cap_addr_q <= '0;
        end else begin
            nvm_cap_q      <= NVM_RD;
            nvm_cap_addr_q <= NVM_ADDR;
        end
    end

    generate
        for (genvar i = 0; i < NVM_WORDS; i++) begin : g_shadow
            always_ff @(posedge CLK_SYS) begin
                if (rst_int) begin
                    nvm_shadow_q[i] <= 8'h00;
                end else if (nvm_cap_q && nvm_cap_addr_q == NAW'(i)) begin
                    nvm_shadow_q[i] <= NVM_DATA;
                end
            end
        end
    endgenerate

    // Power control survives suspend; soft reset bit never reads back as set
    always_ff @(posedge CLK_SYS) begin
        if (rst_int) begin
            pwr_q <= PWR_RST;
        end else if (wr_pwr) begin
            pwr_q <= REG_WDATA & ~(8'h01 << SRST_BIT);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (rst_int || state_q == MPM_ST_SUSPEND || state_q == MPM_ST_STARTUP || srst) begin
            opm_q   <= OPM_RST;
            axen_q  <= AXEN_RST;
            xyrep_q <= REP_RST;
            zrep_q  <= REP_RST;
        end else if (REG_WR && acc_ok_wr) begin
            case (REG_ADDR)
                ADDR_OPM:   opm_q <= REG_WDATA;
                ADDR_AXEN:  axen_q <= REG_WDATA;
                ADDR_XYREP: xyrep_q <= REG_WDATA;
                ADDR_ZREP:  zrep_q <= REG_WDATA;
                default:    opm_q <= opm_q;
            endcase
        end else if (state_q == MPM_ST_FORCED && meas_done) begin
            opm_q[OPM_MODE_LSB +: 2] <= OPM_SLEEP;
        end
    end

    // Measurement scheduling
    assign n_xy = {1'b0, xyrep_q} + 9'h001;
    assign n_z  = {1'b0, zrep_q} + 9'h001;

    always_comb begin
        meas_load = TW'(MEAS_OVH_CYC);
        if (axen_q[AX_X] || axen_q[AX_Y]) begin
            meas_load = meas_load + TW'(PLANAR_REPETITION_COUNT_CYC * int'(n_xy));
        end
        if (axen_q[AX_Z]) begin
            meas_load = meas_load + TW'(Z_REP_CYC * int'(n_z));
        end
    end

    assign odr_load   = TW'(ODR_CYC[opm_q[OPM_RATE_LSB +: 3]]);
    assign forced_wr  = wr_opm && (opm_wmode == OPM_FORCED) && (state_d == MPM_ST_FORCED);
    // Next period waits for both the rate timer and a running cycle
    assign norm_start = (state_q == MPM_ST_NORMAL) && !odr_busy && !meas_busy;
    assign meas_start = forced_wr || norm_start;
    assign meas_stop  = (state_d != MPM_ST_NORMAL) && (state_d != MPM_ST_FORCED);

    mpm_cnt_timer #(
        .W (TW)
    ) u_meas_timer (
        .clk   (CLK_SYS),
        .rst   (rst_int),
        .start (meas_start),
        .stop  (meas_stop),
        .load  (meas_load),
        .busy  (meas_busy),
        .done  (meas_done)
    );

    mpm_cnt_timer #(
        .W (TW)
    ) u_odr_timer (
        .clk   (CLK_SYS),
        .rst   (rst_int),
        .start (norm_start),
        .stop  (state_q != MPM_ST_NORMAL),
        .load  (odr_load),
        .busy  (odr_busy),
        .done  ()
    );

    assign MEAS_ACTIVE = meas_busy;

    // Complete packet lands at once; an aborted cycle never raises done
    always_ff @(posedge CLK_SYS) begin
        if (rst_int || state_q == MPM_ST_SUSPEND || state_q == MPM_ST_STARTUP || srst) begin
            dx_q         <= '0;
            dy_q         <= '0;
            dz_q         <= '0;
            dr_q         <= '0;
            DATA_UPDATED <= 1'b0;
        end else if (meas_done && active) begin
            dx_q         <= axen_q[AX_X] ? AFE_X : dx_q;
            dy_q         <= axen_q[AX_Y] ? AFE_Y : dy_q;
            dz_q         <= axen_q[AX_Z] ? AFE_Z : dz_q;
            dr_q         <= AFE_R;
            DATA_UPDATED <= 1'b1;
        end else begin
            DATA_UPDATED <= 1'b0;
        end
    end

    assign nvm_off = REG_ADDR - ADDR_NVM_BASE;

    always_comb begin
        rd_mux = 8'h00;
        case (REG_ADDR)
            ADDR_ID:    rd_mux = ID_CODE;
            ADDR_XL:    rd_mux = {dx_q[4:0], 3'h0};
            ADDR_XM:    rd_mux = dx_q[12:5];
            ADDR_YL:    rd_mux = {dy_q[4:0], 3'h0};
            ADDR_YM:    rd_mux = dy_q[12:5];
            ADDR_ZL:    rd_mux = {dz_q[6:0], 1'b0};
            ADDR_ZM:    rd_mux = dz_q[14:7];
            ADDR_RL:    rd_mux = {dr_q[5:0], 2'h0};
            ADDR_RM:    rd_mux = dr_q[13:6];
            ADDR_PWR:   rd_mux = pwr_q;
            ADDR_OPM:   rd_mux = opm_q;
            ADDR_AXEN:  rd_mux = axen_q;
            ADDR_XYREP: rd_mux = xyrep_q;
            ADDR_ZREP:  rd_mux = zrep_q;
            default: begin
                if (REG_ADDR >= ADDR_NVM_BASE && int'(nvm_off) < NVM_WORDS) begin
                    rd_mux = nvm_shadow_q[nvm_off[NAW-1:0]];
                end
            end
        endcase
    end

    // Blocked read: I2C still clocks out a byte, so it sends zero; SPI stays off the line
    always_ff @(posedge CLK_SYS) begin
        if (rst_int) begin
            REG_RDATA  <= 8'h00;
            REG_RD_ACK <= 1'b0;
            REG_SDO_OE <= 1'b0;
        end else if (REG_RD) begin
            REG_RD_ACK <= 1'b1;
            REG_RDATA  <= acc_ok_rd ? rd_mux : 8'h00;
            REG_SDO_OE <= acc_ok_rd || !IF_IS_SPI;
        end else begin
            REG_RD_ACK <= 1'b0;
            REG_SDO_OE <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (rst_int) begin
            THREE_WIRE_EN <= 1'b0;
            AFE_AXIS_EN   <= 3'h0;
            MODE          <= 3'h0;
        end else begin
            THREE_WIRE_EN <= pwr_q[THREE_WIRE_SERIAL_ENABLE_BIT];
            AFE_AXIS_EN   <= axen_q[2:0];
            MODE          <= state_d;
        end
    end

endmodule

// ==== verif/mpm_far_model.sv ====
`timescale 1ns/1ps
module mpm_far_model
    import mpm_pkg::*;
#(
    parameter int          AW = 3,
    parameter logic [12:0] XV = 13'h1a5c,
    parameter logic [12:0] YV = 13'h0b37,
    parameter logic [14:0] ZV = 15'h5e21,
    parameter logic [13:0] RV = 14'h2d4b
) (
    input  wire logic          clk,
    input  wire logic          nvm_rd,
    input  wire logic [AW-1:0] nvm_addr,
    output logic      [7:0]    nvm_data,
    output logic      [12:0]   afe_x,
    output logic      [12:0]   afe_y,
    output logic      [14:0]   afe_z,
    output logic      [13:0]   afe_r
);
    initial nvm_data = 8'h00;
    // Outside the valid cycle the store output toggles so stale data cannot pass
    always_ff @(posedge clk) begin
        if (nvm_rd) begin
            nvm_data <= 8'ha0 ^ 8'(nvm_addr);
        end else begin
            nvm_data <= ~nvm_data;
        end
    end
    assign afe_x = XV;
    assign afe_y = YV;
    assign afe_z = ZV;
    assign afe_r = RV;
endmodule

// ==== verif/mpm_top_assertions.sv ====
`timescale 1ns/1ps
module mpm_top_checker
    import mpm_pkg::*;
(
    input wire logic       CLK_SYS,
    input wire logic       RST,
    input wire logic       VDD_OK,
    input wire logic       VDDIO_OK,
    input wire logic       IF_IS_SPI,
    input wire logic       REG_WR,
    input wire logic       REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    input wire logic       REG_RD_ACK,
    input wire logic       REG_SDO_OE,
    input wire logic       MEAS_ACTIVE,
    input wire logic       DATA_UPDATED,
    input wire logic [2:0] MODE
);
    logic pw_wr;
    logic om_wr;
    logic id_rd;
    assign pw_wr = REG_WR && REG_ADDR == ADDR_PWR;
    assign om_wr = REG_WR && REG_ADDR == ADDR_OPM;
    assign id_rd = REG_RD && REG_ADDR == ADDR_ID && MODE == 3'h1;

    default clocking cb @(posedge CLK_SYS); endclocking
    // Supply loss acts as reset, so it also disables the checks
    default disable iff (RST || !VDD_OK || !VDDIO_OK);

    a_read_ack: assert property (REG_RD |=> REG_RD_ACK)
        else $error("read not acknowledged");
    a_id_zero_i2c: assert property (id_rd && !IF_IS_SPI |=> REG_SDO_OE && REG_RDATA == 8'h00)
        else $error("blocked id read not zero on i2c");
    a_id_hiz_spi: assert property (id_rd && IF_IS_SPI |=> REG_RD_ACK && !REG_SDO_OE)
        else $error("blocked id read drove spi line");
    a_power_wake: assert property (MODE == 3'h1 && pw_wr && REG_WDATA[PWR_BIT] |=> MODE == 3'h2)
        else $error("power bit did not wake to sleep");
    a_power_off: assert property (MODE inside {3'h2, 3'h3} && pw_wr && !REG_WDATA[PWR_BIT]
        |=> MODE == 3'h1)
        else $error("clearing power bit did not suspend");
    a_mode_sleep: assert property (MODE inside {3'h3, 3'h4} && om_wr
        && REG_WDATA[2:1] == OPM_SLEEP |=> MODE == 3'h2)
        else $error("mode field 11 did not return to sleep");
    a_forced_go: assert property (MODE == 3'h2 && om_wr && REG_WDATA[2:1] == OPM_FORCED
        |=> MODE == 3'h4 && MEAS_ACTIVE)
        else $error("forced write did not start a measurement");
    a_normal_go: assert property (MODE == 3'h2 && om_wr && REG_WDATA[2:1] == OPM_NORMAL
        |=> MODE == 3'h3)
        else $error("normal write did not enter normal mode");
    a_locked_write: assert property (MODE == 3'h1 && REG_WR && REG_ADDR != ADDR_PWR
        |=> MODE == 3'h1)
        else $error("blocked write changed state");
    a_update_cause: assert property ($rose(DATA_UPDATED) |-> $past(MEAS_ACTIVE, 2))
        else $error("data updated without a measurement");
    a_forced_done: assert property (DATA_UPDATED && $past(MODE) == 3'h4 && !$past(REG_WR)
        |-> MODE == 3'h2)
        else $error("forced measurement did not end in sleep");
    a_supply_off: assert property (disable iff (RST)
        (!VDD_OK || !VDDIO_OK) [*4] |=> MODE == 3'h0)
        else $error("device ran without both supplies");

    c_forced_done: cover property (DATA_UPDATED && MODE == 3'h2);
    c_normal_update: cover property (DATA_UPDATED && MODE == 3'h3);
    c_suspend_entry: cover property (MODE == 3'h2 ##1 MODE == 3'h1);
endmodule

bind mpm_top mpm_top_checker mpm_top_checker_inst (
    .CLK_SYS(CLK_SYS), .RST(RST), .VDD_OK(VDD_OK), .VDDIO_OK(VDDIO_OK),
    .IF_IS_SPI(IF_IS_SPI), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_RD_ACK(REG_RD_ACK),
    .REG_SDO_OE(REG_SDO_OE), .MEAS_ACTIVE(MEAS_ACTIVE), .DATA_UPDATED(DATA_UPDATED),
    .MODE(MODE)
);

// ==== verif/mpm_top_tb.sv ====
`timescale 1ns/1ps
module mpm_top_tb
    import mpm_pkg::*;
;
    localparam int          TICK  = 100_000;
    localparam logic [7:0]  IDV   = 8'h3c; // Arbitrary identification value
    localparam logic [12:0] XV    = 13'h1a5c;
    localparam logic [14:0] ZV    = 15'h5e21;
    localparam logic [13:0] RV    = 14'h2d4b;
    // Rep times scaled up tenfold against the slow tick: 145, 500, 980 cycles
    localparam int          MEAS1 = 980 + 2 * 145 + 500;
    localparam int          PER7  = TICK / 30;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        vdd_ok = 1'b1;
    logic        vddio_ok = 1'b0;
    logic        spi = 1'b0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic [7:0]  rdata, nvm_data, rv;
    logic        ack, oe, nvm_rd, meas, upd, tw;
    logic [2:0]  nvm_addr, axen, mode;
    logic [12:0] ax, ay;
    logic [14:0] az;
    logic [13:0] ar;
    int          num_errors = 0;
    int          total_checks = 0;
    int          upd_cnt = 0;
    int          n;

    always #50 clk = ~clk;
    always @(posedge clk) if (upd === 1'b1) upd_cnt++;

    mpm_top #(.TICK_HZ(TICK), .PLANAR_REPETITION_COUNT_US(1450), .Z_REP_US(5000), .MEAS_OVH_US(9800),
              .ID_CODE(IDV)) mpm_top_inst (
        .CLK_SYS(clk), .RST(rst), .VDD_OK(vdd_ok), .VDDIO_OK(vddio_ok), .IF_IS_SPI(spi),
        .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
        .REG_RD_ACK(ack), .REG_SDO_OE(oe), .NVM_RD(nvm_rd), .NVM_ADDR(nvm_addr),
        .NVM_DATA(nvm_data), .AFE_X(ax), .AFE_Y(ay), .AFE_Z(az), .AFE_R(ar),
        .AFE_AXIS_EN(axen), .MEAS_ACTIVE(meas), .DATA_UPDATED(upd), .THREE_WIRE_EN(tw),
        .MODE(mode));
    mpm_far_model #(.XV(XV), .ZV(ZV), .RV(RV)) mpm_far_model_inst (
        .clk(clk), .nvm_rd(nvm_rd), .nvm_addr(nvm_addr), .nvm_data(nvm_data),
        .afe_x(ax), .afe_y(ay), .afe_z(az), .afe_r(ar));

    task summarize;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(string what, logic [15:0] exp, logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task wr_reg(logic [7:0] a, logic [7:0] d);
        @(posedge clk); wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk); wr <= 1'b0;
    endtask
    task rd_reg(logic [7:0] a);
        @(posedge clk); rd <= 1'b1; addr <= a;
        @(posedge clk); rd <= 1'b0;
        #1; rv = rdata;
        chk("read ack", 1, 16'(ack));
    endtask
    task wait_mode(logic [2:0] m, int lim);
        #1;
        for (int i = 0; i < lim && mode !== m; i++) begin
            @(posedge clk); #1;
        end
        chk("mode", 16'(m), 16'(mode));
        if (mode !== m) summarize;
    endtask
    task wait_upd(int lim);
        #1; n = 0;
        while (upd !== 1'b1 && n < lim) begin
            @(posedge clk); #1; n++;
        end
        if (n >= lim) begin chk("update wait", 1, 0); summarize; end
    endtask

    task t_startup;
        @(posedge clk); rst <= 1'b0;
        repeat (10) @(posedge clk);
        #1; chk("mode one supply", 0, 16'(mode));
        @(posedge clk); vddio_ok <= 1'b1;
        n = 0;
        for (int k = 0; k < 100 && mode !== 3'h1; k++) begin
            @(posedge clk); #1; if (nvm_rd === 1'b1) n++;
        end
        chk("store reads", 8, 16'(n));
        chk("startup mode", 1, 16'(mode));
        rd_reg(ADDR_PWR); chk("power reset", 16'(PWR_RST), 16'(rv));
        $display("test startup done");
    endtask
    task t_suspend;
        rd_reg(ADDR_ID); chk("id i2c", 0, 16'(rv));
        chk("oe i2c", 1, 16'(oe));
        @(posedge clk); spi <= 1'b1;
        rd_reg(ADDR_ID); chk("oe spi", 0, 16'(oe));
        @(posedge clk); spi <= 1'b0;
        wr_reg(ADDR_AXEN, 8'h01);
        wr_reg(ADDR_PWR, 8'h04);
        rd_reg(ADDR_PWR); chk("power reg", 16'h04, 16'(rv));
        chk("three wire", 1, 16'(tw));
        wr_reg(ADDR_PWR, 8'h05); wait_mode(3'h2, 3);
        rd_reg(ADDR_ID); chk("id sleep", 16'(IDV), 16'(rv));
        rd_reg(ADDR_AXEN); chk("axis enable", 16'(AXEN_RST), 16'(rv));
        rd_reg(ADDR_NVM_BASE); chk("shadow copy", 16'ha0, 16'(rv));
        $display("test suspend done");
    endtask
    task t_forced;
        wr_reg(ADDR_XYREP, 8'h01);
        wr_reg(ADDR_OPM, 8'h02); #1;
        chk("forced mode", 4, 16'({mode, meas})  >> 1);
        wait_upd(3000);
        chk("meas time", 16'(MEAS1), 16'((n >= MEAS1 - 1 && n <= MEAS1 + 1) ? MEAS1 : n));
        wait_mode(3'h2, 2);
        rd_reg(ADDR_OPM); chk("mode field", 16'h06, 16'(rv));
        rd_reg(ADDR_XM); chk("x msb", 16'(XV[12:5]), 16'(rv));
        rd_reg(ADDR_ZM); chk("z msb", 16'(ZV[14:7]), 16'(rv));
        rd_reg(ADDR_RL); chk("r lsb", 16'({RV[5:0], 2'b00}), 16'(rv));
        n = upd_cnt;
        wr_reg(ADDR_OPM, 8'h02);
        repeat (300) @(posedge clk);
        wr_reg(ADDR_OPM, 8'h02);
        repeat (2 * MEAS1) @(posedge clk);
        chk("restart updates", 1, 16'(upd_cnt - n));
        $display("test forced done");
    endtask
    task t_normal;
        wr_reg(ADDR_OPM, 8'h38); wait_mode(3'h3, 2);
        wait_upd(3000); @(posedge clk);
        wait_upd(5000); n++;
        chk("rate period", 16'(PER7), 16'((n >= PER7 - 2 && n <= PER7 + 2) ? PER7 : n));
        wr_reg(ADDR_PWR, 8'h07); wait_mode(3'h2, 3);
        rd_reg(ADDR_XYREP); chk("rep after soft reset", 16'(REP_RST), 16'(rv));
        wr_reg(ADDR_OPM, 8'h38); wait_mode(3'h3, 2);
        wr_reg(ADDR_OPM, 8'h3e); wait_mode(3'h2, 2);
        wr_reg(ADDR_OPM, 8'h38); wait_mode(3'h3, 2);
        wr_reg(ADDR_PWR, 8'h04); wait_mode(3'h1, 2);
        rd_reg(ADDR_PWR); chk("power kept", 16'h04, 16'(rv));
        wr_reg(ADDR_PWR, 8'h05); wait_mode(3'h2, 3);
        rd_reg(ADDR_OPM); chk("operating_mode_field lost", 16'(OPM_RST), 16'(rv));
        $display("test normal done");
    endtask
    task t_supply;
        @(posedge clk); vdd_ok <= 1'b0;
        wait_mode(3'h0, 5);
        @(posedge clk); vdd_ok <= 1'b1;
        wait_mode(3'h1, 40);
        rd_reg(ADDR_PWR); chk("power after loss", 16'(PWR_RST), 16'(rv));
        wr_reg(ADDR_PWR, 8'h05); wait_mode(3'h2, 3);
        $display("test supply done");
    endtask

    initial begin
        repeat (20) @(posedge clk);
        t_startup;
        t_suspend;
        t_forced;
        t_normal;
        t_supply;
        summarize;
    end
endmodule
